// ==== logic/tls_pkg.sv ====
// Constants and carrier types for the timing lock and strap block.
package tls_pkg;

  // ==========================================================================
  // Host port selects and register indices.
  localparam logic       PORT_INDEX     = 1'b0;
  localparam logic       PORT_DATA      = 1'b1;
  localparam logic [7:0] IDX_LOCK       = 8'h35;
  localparam logic [7:0] IDX_STRAP_LOW  = 8'h36;
  localparam logic [7:0] IDX_STRAP_HIGH = 8'h37;
  localparam logic [7:0] IDX_KEY        = 8'h38;
  localparam logic [7:0] IDX_H_FIRST    = 8'h00;
  localparam logic [7:0] IDX_H_LAST     = 8'h05;
  localparam logic [7:0] IDX_V_06       = 8'h06;
  localparam logic [7:0] IDX_V_07       = 8'h07;
  localparam logic [7:0] IDX_V_09       = 8'h09;
  localparam logic [7:0] IDX_V_10       = 8'h10;
  localparam logic [7:0] IDX_V_11       = 8'h11;
  localparam logic [7:0] IDX_V_15       = 8'h15;
  localparam logic [7:0] IDX_V_16       = 8'h16;
  localparam logic [7:0] IDX_MODE_17    = 8'h17;

  // ==========================================================================
  // Protected bit masks inside fully and partly locked timing registers.
  localparam logic [7:0] MASK_ALL  = 8'hff;
  localparam logic [7:0] MASK_07_V = 8'had;
  localparam logic [7:0] MASK_09_V = 8'h20;
  localparam logic [7:0] MASK_11_V = 8'h0f;
  localparam logic [7:0] MASK_17_H = 8'h04;

  // ==========================================================================
  // Field positions, reset values and the unlock key.
  localparam int         VERT_LOCK_BIT   = 4;
  localparam int         HORZ_LOCK_BIT   = 5;
  localparam logic [7:0] LOCK_WR_MASK    = 8'h3f;
  localparam logic [7:0] LOCK_RESET      = 8'h00;
  localparam logic [7:0] KEY_RESET       = 8'h00;
  localparam logic [7:0] KEY_CARE_MASK   = 8'hcc;
  localparam logic [7:0] KEY_VALUE       = 8'h48;
  localparam logic [7:0] LOCKED_READ     = 8'h00;
  localparam logic [1:0] CLK_SEL_RESET   = 2'h0;
  localparam logic [4:0] MEM_HI_RESET    = 5'h00;
  localparam logic [15:0] STRAP_RESET    = 16'h0000;
  localparam int         STRAP_ROM_FULL  = 3;
  localparam int         STRAP_DECODE    = 4;
  localparam int         STRAP_SETUP     = 8;
  localparam int         STRAP_MON_EXT   = 10;
  localparam int         STRAP_NOWS      = 11;
  localparam int         STRAP_MEMCS16   = 12;
  localparam int         STRAP_MON_LSB   = 13;

  // ==========================================================================
  // ROM region address patterns on bits 19:15 and 19:11.
  localparam logic [4:0] ROM_REGION_HI   = 5'h18;
  localparam logic [8:0] ROM_HOLE        = 9'h18c;

  // ==========================================================================
  // Forwarded timing register write.
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
    logic [7:0] bit_enable;
  } tls_crt_wr_type;

endpackage : tls_pkg

// ==== logic/tls_strap_capture.sv ====
// Captures the strapping pin levels once after reset release.
`timescale 1ns/1ps
module tls_strap_capture
  import tls_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] strapping_pin_bus,
  output logic      [WIDTH-1:0] strap_q
);

  logic taken_q;

  // ==========================================================================
  // The first edge after release samples the pins; later edges hold them.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      taken_q <= 1'b0;
      strap_q <= STRAP_RESET[WIDTH-1:0];
    end
    else if (!taken_q)
    begin
      taken_q <= 1'b1;
      strap_q <= strapping_pin_bus; // [R9]
    end
  end

endmodule // tls_strap_capture

// ==== logic/tls_window_adder.sv ====
// Forms the upper display memory address from the CPU window base.
`timescale 1ns/1ps
module tls_window_adder
  import tls_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       window_enable,
  input  wire logic [3:0] window_base,
  input  wire logic       base_bit18,
  input  wire logic [3:0] cpu_addr_17_14,
  output logic      [4:0] mem_addr_18_14
);

  logic [3:0] sum;

  // ==========================================================================
  // Base is added in 16 KByte steps; the top bit comes in only while the window is enabled.
  always_comb
  begin
    sum = cpu_addr_17_14;
    if (window_enable)
    begin
      sum = cpu_addr_17_14 + window_base; // [R2] [R3]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_addr_18_14 <= MEM_HI_RESET;
    end
    else
    begin
      mem_addr_18_14 <= {base_bit18 & window_enable, sum}; // [R4]
    end
  end

endmodule // tls_window_adder

// ==== logic/tls_timing_lock.sv ====
// Timing lock, CPU window base and strap configuration registers.
//
// Contract
// R1 - Clock lock freezes the clock select bits.
// R2 - Window base selects 64 KByte steps; the code adds it at address bit 14, in 16 KByte steps.
// R3 - Base adds to CPU address bits 17-14.
// R4 - External bit acts as address bit 18.
// R5 - Vertical lock blocks listed vertical timing writes.
// R6 - Retrace-end bit also locks indices 06H, 07H.
// R7 - Horizontal lock blocks 00H-05H and 17H bit 2.
// R8 - Retrace-end bit locks 00H-05H, not 17H.
// R9 - Straps captured at reset; read-only bytes.
// R10 - Strap bit 3 selects the ROM hole.
// R11 - Strap bit 4 selects decode and ROM select.
// R12 - Strap bit 8 picks the setup bit.
// R13 - Strap bit 11 sets wait and claim style.
// R14 - Strap bit 12 sets MEMCS16 and DAC claims.
// R15 - Straps present the monitor type code.
// R16 - Extension registers locked until key written.
// R17 - Locked fields keep their stored value.
// R18 - Lock register reserved bits read zero.
`timescale 1ns/1ps
module tls_timing_lock
  import tls_pkg::*;
#(
  parameter int STRAP_WIDTH = 16
)
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   io_wr,
  input  wire logic                   io_rd,
  input  wire logic                   io_sel,
  input  wire logic [7:0]             io_wdata,
  output logic      [7:0]             io_rdata,
  output logic                        io_rd_valid,
  input  wire logic [7:0]             crt_rd_data,
  output tls_crt_wr_type              crt_wr,
  output logic                        crt_wr_valid,
  input  wire logic                   retrace_end_protect,
  input  wire logic                   clock_select_lock,
  input  wire logic                   misc_wr,
  input  wire logic [1:0]             misc_clk_sel,
  output logic      [1:0]             video_clk_sel,
  input  wire logic                   window_enable,
  input  wire logic                   base_bit18,
  input  wire logic [3:0]             cpu_addr_17_14,
  output logic      [4:0]             mem_addr_18_14,
  input  wire logic [STRAP_WIDTH-1:0] strapping_pin_bus,
  input  wire logic [19:11]           rom_probe_addr,
  output logic                        rom_region_hit,
  output logic                        decode_uses_sa16,
  output logic                        upper_address_pin_is_rom_chip_select,
  output logic                        setup_bit_is_bit4,
  output logic                        nows_enable,
  output logic                        local_bus_claim_tristate,
  output logic                        memcs16_internal,
  output logic                        dac_claim_enable,
  output logic      [2:0]             monitor_type,
  output logic                        monitor_type_ext,
  output logic                        extensions_unlocked
);

  logic [7:0]             index_q;
  logic [7:0]             key_q;
  logic [7:0]             lock_q;
  logic [1:0]             clk_sel_q;
  logic [STRAP_WIDTH-1:0] strap_q;
  logic [7:0]             rdata_q;
  logic                   rd_valid_q;
  tls_crt_wr_type         crt_wr_q;
  logic                   crt_wr_valid_q;
  logic                   unlocked;
  logic                   vlock;
  logic                   hlock;
  logic                   data_wr;
  logic                   own_index;
  logic [7:0]             locked_bits;
  logic [7:0]             read_value;

  // ==========================================================================
  // Key decode and the two timing locks.
  assign unlocked = (key_q & KEY_CARE_MASK) == KEY_VALUE; // [R16]
  assign vlock    = lock_q[VERT_LOCK_BIT];
  assign hlock    = lock_q[HORZ_LOCK_BIT];
  assign data_wr  = io_wr && (io_sel == PORT_DATA);
  assign own_index = (index_q == IDX_LOCK)
                  || (index_q == IDX_STRAP_LOW)
                  || (index_q == IDX_STRAP_HIGH)
                  || (index_q == IDX_KEY);

  // ==========================================================================
  // Bits of the addressed timing register that a write may not change.
  always_comb
  begin
    locked_bits = 8'h00;
    if ((index_q >= IDX_H_FIRST) && (index_q <= IDX_H_LAST))
    begin
      if (hlock || retrace_end_protect)
      begin
        locked_bits = MASK_ALL; // [R7] [R8]
      end
    end
    else
    begin
      case (index_q)
        IDX_V_06:
        begin
          if (vlock || retrace_end_protect)
          begin
            locked_bits = MASK_ALL; // [R5] [R6]
          end
        end
        IDX_V_07:
        begin
          if (vlock || retrace_end_protect)
          begin
            locked_bits = MASK_07_V; // [R5] [R6]
          end
        end
        IDX_V_09:
        begin
          if (vlock)
          begin
            locked_bits = MASK_09_V; // [R5]
          end
        end
        IDX_V_10,
        IDX_V_15,
        IDX_V_16:
        begin
          if (vlock)
          begin
            locked_bits = MASK_ALL; // [R5]
          end
        end
        IDX_V_11:
        begin
          if (vlock)
          begin
            locked_bits = MASK_11_V; // [R5]
          end
        end
        IDX_MODE_17:
        begin
          if (hlock)
          begin
            locked_bits = MASK_17_H; // [R7] [R8]
          end
        end
        default:
        begin
          locked_bits = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================================
  // Index register.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      index_q <= 8'h00;
    end
    else if (io_wr && (io_sel == PORT_INDEX))
    begin
      index_q <= io_wdata;
    end
  end

  // ==========================================================================
  // Unlock key register, always reachable.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_q <= KEY_RESET; // [R16]
    end
    else if (data_wr && (index_q == IDX_KEY))
    begin
      key_q <= io_wdata;
    end
  end

  // ==========================================================================
  // Timing lock and window base register.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_q <= LOCK_RESET;
    end
    else if (data_wr && (index_q == IDX_LOCK) && unlocked) // [R16]
    begin
      lock_q <= io_wdata & LOCK_WR_MASK; // [R18]
    end
  end

  // ==========================================================================
  // Forwarded timing writes carry per-bit enables.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crt_wr_q       <= '0;
      crt_wr_valid_q <= 1'b0;
    end
    else
    begin
      crt_wr_valid_q <= data_wr && !own_index;
      if (data_wr && !own_index)
      begin
        crt_wr_q.index      <= index_q;
        crt_wr_q.data       <= io_wdata;
        crt_wr_q.bit_enable <= ~locked_bits; // [R17]
      end
    end
  end

  assign crt_wr       = crt_wr_q;
  assign crt_wr_valid = crt_wr_valid_q;

  // ==========================================================================
  // Clock select bits of the miscellaneous output register.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_sel_q <= CLK_SEL_RESET;
    end
    else if (misc_wr && !clock_select_lock) // [R1]
    begin
      clk_sel_q <= misc_clk_sel;
    end
  end

  assign video_clk_sel = clk_sel_q;

  // ==========================================================================
  // Read path; strap bytes never take writes.
  always_comb
  begin
    read_value = crt_rd_data;
    if (io_sel == PORT_INDEX)
    begin
      read_value = index_q;
    end
    else
    begin
      case (index_q)
        IDX_KEY:
        begin
          read_value = key_q;
        end
        IDX_LOCK:
        begin
          read_value = unlocked ? lock_q : LOCKED_READ; // [R16] [R18]
        end
        IDX_STRAP_LOW:
        begin
          read_value = unlocked ? strap_q[7:0] : LOCKED_READ; // [R9]
        end
        IDX_STRAP_HIGH:
        begin
          read_value = unlocked ? strap_q[15:8] : LOCKED_READ; // [R9]
        end
        default:
        begin
          read_value = crt_rd_data;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q    <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= io_rd;
      if (io_rd)
      begin
        rdata_q <= read_value;
      end
    end
  end

  assign io_rdata            = rdata_q;
  assign io_rd_valid         = rd_valid_q;
  assign extensions_unlocked = unlocked;

  // ==========================================================================
  // Strap capture and the display window adder.
  tls_strap_capture #(
    .WIDTH             (STRAP_WIDTH)
  ) u_strap (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .strapping_pin_bus (strapping_pin_bus),
    .strap_q           (strap_q)
  );

  tls_window_adder u_window (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .window_enable  (window_enable),
    .window_base    (lock_q[3:0]),
    .base_bit18     (base_bit18),
    .cpu_addr_17_14 (cpu_addr_17_14),
    .mem_addr_18_14 (mem_addr_18_14)
  );

  // ==========================================================================
  // Strap decodes.
  always_comb
  begin
    rom_region_hit = 1'b0;
    if (rom_probe_addr[19:15] == ROM_REGION_HI)
    begin
      rom_region_hit = strap_q[STRAP_ROM_FULL]
                    || (rom_probe_addr != ROM_HOLE); // [R10]
    end
  end

  assign decode_uses_sa16  = !strap_q[STRAP_DECODE]; // [R11]
  assign upper_address_pin_is_rom_chip_select =
    !strap_q[STRAP_DECODE]; // [R11]
  assign setup_bit_is_bit4 = strap_q[STRAP_SETUP]; // [R12]
  assign nows_enable       = strap_q[STRAP_NOWS]; // [R13]
  assign local_bus_claim_tristate = strap_q[STRAP_NOWS]; // [R13]
  assign memcs16_internal  = strap_q[STRAP_MEMCS16]; // [R14]
  assign dac_claim_enable  = strap_q[STRAP_MEMCS16]; // [R14]
  assign monitor_type      = strap_q[STRAP_MON_LSB +: 3]; // [R15]
  assign monitor_type_ext  = strap_q[STRAP_MON_EXT]; // [R15]

endmodule // tls_timing_lock

// ==== verification/tls_timing_lock_properties.sv ====
// Concurrent checks on the ports of the timing lock block.
`timescale 1ns/1ps
module tls_timing_lock_properties
  import tls_pkg::*;
(
  input wire logic           core_clk,
  input wire logic           rst_n,
  input wire logic           io_rd,
  input wire logic           io_rd_valid,
  input wire tls_crt_wr_type crt_wr,
  input wire logic           crt_wr_valid,
  input wire logic           retrace_end_protect,
  input wire logic           clock_select_lock,
  input wire logic           misc_wr,
  input wire logic [1:0]     misc_clk_sel,
  input wire logic [1:0]     video_clk_sel,
  input wire logic           window_enable,
  input wire logic           base_bit18,
  input wire logic [3:0]     cpu_addr_17_14,
  input wire logic [4:0]     mem_addr_18_14,
  input wire logic [19:11]   rom_probe_addr,
  input wire logic           rom_region_hit,
  input wire logic           decode_uses_sa16,
  input wire logic           upper_address_pin_is_rom_chip_select,
  input wire logic           nows_enable,
  input wire logic           local_bus_claim_tristate,
  input wire logic           memcs16_internal,
  input wire logic           dac_claim_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Assertions.
  rd_answer_a: assert property (io_rd |=> io_rd_valid)
    else $error("read gave no answer");
  rd_quiet_a: assert property (!io_rd |=> !io_rd_valid)
    else $error("answer without a read");
  clk_hold_a: assert property (
    clock_select_lock |=> $stable(video_clk_sel))
    else $error("clock select moved while locked");
  clk_load_a: assert property (misc_wr && !clock_select_lock
    |=> video_clk_sel == $past(misc_clk_sel))
    else $error("clock select not loaded");
  addr_pass_a: assert property (!window_enable
    |=> mem_addr_18_14 == {1'b0, $past(cpu_addr_17_14)})
    else $error("address not passed through");
  addr_bit18_a: assert property (window_enable
    |=> mem_addr_18_14[4] == $past(base_bit18))
    else $error("address bit 18 wrong");
  rom_chip_select_pair_a: assert property (
    decode_uses_sa16 == upper_address_pin_is_rom_chip_select)
    else $error("decode and rom select disagree");
  claim_pair_a: assert property (
    nows_enable == local_bus_claim_tristate
    && memcs16_internal == dac_claim_enable)
    else $error("strap outputs disagree");
  rom_out_a: assert property (
    rom_probe_addr[19:15] != 5'h18 |-> !rom_region_hit)
    else $error("rom hit outside region");
  retrace_lock_a: assert property (
    crt_wr_valid && $past(retrace_end_protect)
    && crt_wr.index <= 8'h05 |-> crt_wr.bit_enable == 8'h00)
    else $error("horizontal write passed retrace lock");

  // ==========================================================================
  // Covers.
  rd_seen_c: cover property (io_rd_valid);
  lock_seen_c: cover property (crt_wr_valid && crt_wr.bit_enable == 8'h00);
  hit_seen_c: cover property (rom_region_hit);
endmodule // tls_timing_lock_properties

// ==== verification/tls_host_model.sv ====
// Host processor model driving the index and data port.
`timescale 1ns/1ps
module tls_host_model
(
  input  wire logic       core_clk,
  output logic            io_wr,
  output logic            io_rd,
  output logic            io_sel,
  output logic      [7:0] io_wdata,
  input  wire logic [7:0] io_rdata,
  input  wire logic       io_rd_valid
);
  initial
  begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_sel = 1'b0;
    io_wdata = 8'h00;
  end

  task automatic wr(input logic s, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    io_wr = 1'b1;
    io_sel = s;
    io_wdata = d;
    @(posedge core_clk);
    #1;
    io_wr = 1'b0;
    io_wdata = ~d;
  endtask

  task automatic rd(output logic [7:0] d, output logic ok);
    @(posedge core_clk);
    #1;
    io_rd = 1'b1;
    io_sel = 1'b1;
    @(posedge core_clk);
    #1;
    io_rd = 1'b0;
    ok = io_rd_valid;
    d = io_rdata;
  endtask

  task automatic unlock();
    wr(1'b0, 8'h38);
    wr(1'b1, 8'h7b);
  endtask
endmodule // tls_host_model

// ==== verification/tls_timing_lock_tb_top.sv ====
// Testbench for the timing lock and strap block.
`timescale 1ns/1ps
module tls_timing_lock_tb_top;
  import tls_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr, rd, sel, rv, cv, un, hit;
  logic ret, ckl, mw, wen, b18;
  logic [7:0] wd, rdat, crd;
  logic [1:0] msel, vsel;
  logic [3:0] cpu;
  logic [4:0] mad;
  logic [15:0] strap;
  logic [19:11] probe;
  wire  [10:0] so;
  tls_crt_wr_type cw;
  logic [15:0] sv [2] = '{16'hb5c9, 16'h4a36};
  logic [7:0] ix [12] = '{8'h00, 8'h03, 8'h05, 8'h06, 8'h07, 8'h09,
                          8'h10, 8'h11, 8'h15, 8'h16, 8'h17, 8'h20};
  int miscompares = 0;
  int compares = 0;

  always #5 clk = ~clk;

  tls_host_model i_tls_host_model (.core_clk(clk), .io_wr(wr), .io_rd(rd),
    .io_sel(sel), .io_wdata(wd), .io_rdata(rdat), .io_rd_valid(rv));

  tls_timing_lock i_tls_timing_lock (.core_clk(clk), .rst_n(rst_n),
    .io_wr(wr), .io_rd(rd), .io_sel(sel), .io_wdata(wd), .io_rdata(rdat),
    .io_rd_valid(rv), .crt_rd_data(crd), .crt_wr(cw), .crt_wr_valid(cv),
    .retrace_end_protect(ret), .clock_select_lock(ckl), .misc_wr(mw),
    .misc_clk_sel(msel), .video_clk_sel(vsel), .window_enable(wen),
    .base_bit18(b18), .cpu_addr_17_14(cpu), .mem_addr_18_14(mad),
    .strapping_pin_bus(strap), .rom_probe_addr(probe),
    .rom_region_hit(hit), .decode_uses_sa16(so[0]),
    .upper_address_pin_is_rom_chip_select(so[1]),
    .setup_bit_is_bit4(so[2]), .nows_enable(so[3]),
    .local_bus_claim_tristate(so[4]), .memcs16_internal(so[5]),
    .dac_claim_enable(so[6]), .monitor_type(so[9:7]),
    .monitor_type_ext(so[10]), .extensions_unlocked(un));

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wx(input logic [7:0] i, input logic [7:0] d);
    i_tls_host_model.wr(1'b0, i);
    i_tls_host_model.wr(1'b1, d);
  endtask

  task automatic rdx(input logic [7:0] i, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_tls_host_model.wr(1'b0, i);
    i_tls_host_model.rd(d, ok);
    check({15'h0, ok}, 16'h0001);
    check({8'h00, d}, {8'h00, exp});
  endtask

  task automatic boot(input logic [15:0] v);
    rst_n = 1'b0;
    strap = v;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic misc(input logic [1:0] v);
    msel = v;
    mw = 1'b1;
    @(posedge clk);
    #1 mw = 1'b0;
    @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] lmask(input logic [7:0] i, input logic h,
                                       input logic v, input logic r);
    lmask = 8'h00;
    if (i <= 8'h05 && (h || r)) lmask = 8'hff;
    if (i == 8'h06 && (v || r)) lmask = 8'hff;
    if (i == 8'h07 && (v || r)) lmask = 8'had;
    if (i == 8'h09 && v) lmask = 8'h20;
    if ((i == 8'h10 || i == 8'h15 || i == 8'h16) && v) lmask = 8'hff;
    if (i == 8'h11 && v) lmask = 8'h0f;
    if (i == 8'h17 && h) lmask = 8'h04;
  endfunction

  initial
  begin
    {ret, ckl, mw, wen, b18, msel, cpu, probe} = '0;
    crd = 8'h5a;
    foreach (sv[n])
    begin
      boot(sv[n]);
      rdx(8'h36, 8'h00);
      rdx(8'h35, 8'h00);
      i_tls_host_model.unlock();
      check({15'h0, un}, 16'h0001);
      wx(8'h36, ~sv[n][7:0]);
      rdx(8'h36, sv[n][7:0]);
      rdx(8'h37, sv[n][15:8]);
      check({5'h0, so}, {5'h0, sv[n][10], sv[n][15:13], sv[n][12], sv[n][12],
            sv[n][11], sv[n][11], sv[n][8], ~sv[n][4], ~sv[n][4]});
      probe = 9'h18c;
      #1 check({15'h0, hit}, {15'h0, sv[n][3]});
      probe = 9'h180;
      #1 check({15'h0, hit}, 16'h0001);
      probe = 9'h100;
      #1 check({15'h0, hit}, 16'h0000);
      $display("test straps done");
    end
    wx(8'h35, 8'hff);
    rdx(8'h35, 8'h3f);
    wx(8'h38, 8'h4c);
    check({15'h0, un}, 16'h0000);
    rdx(8'h35, 8'h00);
    wx(8'h35, 8'h00);
    i_tls_host_model.unlock();
    rdx(8'h35, 8'h3f);
    rdx(8'h20, 8'h5a);
    $display("test lock register done");
    for (int lk = 0; lk < 4; lk++)
      for (int r = 0; r < 2; r++)
        foreach (ix[k])
        begin
          wx(8'h35, 8'(lk << 4));
          ret = r[0];
          wx(ix[k], 8'hff);
          check({15'h0, cv}, 16'h0001);
          check({8'h00, cw.data}, 16'h00ff);
          check({cw.index, cw.bit_enable},
                {ix[k], ~lmask(ix[k], lk[1], lk[0], r[0])});
        end
    ret = 1'b0;
    $display("test protection done");
    misc(2'h2);
    check({14'h0, vsel}, 16'h0002);
    ckl = 1'b1;
    misc(2'h1);
    check({14'h0, vsel}, 16'h0002);
    ckl = 1'b0;
    $display("test clock select done");
    wx(8'h35, 8'h0c);
    wen = 1'b1;
    b18 = 1'b1;
    cpu = 4'h5;
    repeat (2) @(posedge clk);
    #1 check({11'h0, mad}, 16'h0011);
    wen = 1'b0;
    repeat (2) @(posedge clk);
    #1 check({11'h0, mad}, 16'h0005);
    $display("test window done");
    give_verdict();
  end
endmodule // tls_timing_lock_tb_top

bind tls_timing_lock tls_timing_lock_properties i_tls_timing_lock_properties (
  .core_clk(core_clk), .rst_n(rst_n), .io_rd(io_rd),
  .io_rd_valid(io_rd_valid), .crt_wr(crt_wr), .crt_wr_valid(crt_wr_valid),
  .retrace_end_protect(retrace_end_protect),
  .clock_select_lock(clock_select_lock), .misc_wr(misc_wr),
  .misc_clk_sel(misc_clk_sel), .video_clk_sel(video_clk_sel),
  .window_enable(window_enable), .base_bit18(base_bit18),
  .cpu_addr_17_14(cpu_addr_17_14), .mem_addr_18_14(mem_addr_18_14),
  .rom_probe_addr(rom_probe_addr), .rom_region_hit(rom_region_hit),
  .decode_uses_sa16(decode_uses_sa16),
  .upper_address_pin_is_rom_chip_select(upper_address_pin_is_rom_chip_select),
  .nows_enable(nows_enable),
  .local_bus_claim_tristate(local_bus_claim_tristate),
  .memcs16_internal(memcs16_internal), .dac_claim_enable(dac_claim_enable));
